// >>> drc_defs.vh
// Purpose: Shared constants for the request-driven transfer engine
// Assumes: Included by every design file of the engine
// Notes:   Definitions only
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// Engine states
`define DRC_ST_IDLE   3'h0
`define DRC_ST_LOAD   3'h1
`define DRC_ST_READ   3'h2
`define DRC_ST_WRITE  3'h3
`define DRC_ST_DONE   3'h4

// Address modes
`define DRC_AM_FIXED  2'h0
`define DRC_AM_INCR   2'h1
`define DRC_AM_OFFS   2'h2

// Element size codes (bytes = 1 << code)
`define DRC_SZ_8      2'h0
`define DRC_SZ_16     2'h1
`define DRC_SZ_32     2'h2
`define DRC_SZ_64     2'h3

// Descriptor layout
`define DRC_DESC_W    108
`define DRC_F_SRC     31:0
`define DRC_F_DST     63:32
`define DRC_F_CNT     79:64
`define DRC_F_ESZ     81:80
`define DRC_F_SMODE   83:82
`define DRC_F_DMODE   85:84
`define DRC_F_OFFS    101:86
`define DRC_F_OFFS_MSB 101
`define DRC_F_CHAIN   102
`define DRC_F_CHAIN_CH 106:103
`define DRC_F_AUTO    107

// Fixed routing of shared request sources onto request lines
`define DRC_OST_L0    12
`define DRC_OST_L1    13
`define DRC_OST_L2    18
`define DRC_OST_L3    19
`define DRC_BS1_RX_L  0
`define DRC_BS1_TX_L  1

// Reset values
`define DRC_ADDR_RST  32'h0000_0000
`define DRC_DATA_RST  64'h0000_0000_0000_0000
`define DRC_ZERO32    32'h0000_0000

`endif

// >>> drc_fifo.v
// Purpose: Transfer buffer between the read and write phases
// Assumes: Single clock, synchronous active-low reset
// Notes:   Flush empties the buffer in one cycle
`timescale 1ns/100ps
`include "drc_defs.vh"

module drc_fifo #(
  parameter W = 64,
  parameter D = 4
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rstn,
  input  wire         flush,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  localparam AW = (D > 1) ? $clog2(D) : 1;
  localparam [AW:0] DEPTH = D;

  reg  [W-1:0] mem_q [0:D-1];
  reg  [AW-1:0] wp_q;
  reg  [AW-1:0] rp_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          pop;

  assign in_ready  = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn || flush) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D-1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D-1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// >>> drc_region_check.v
// Purpose: Blocks bus accesses forbidden by the protected regions
// Assumes: Region settings are static while a channel runs
// Notes:   Addresses outside every enabled region are allowed
`timescale 1ns/100ps
`include "drc_defs.vh"

module drc_region_check #(
  parameter NR = 4
) (
  // Access under test
  input  wire [31:0]      addr,
  input  wire             is_write,
  // Region settings, region i in slice i
  input  wire [NR*32-1:0] rgn_base,
  input  wire [NR*32-1:0] rgn_limit,
  input  wire [NR-1:0]    rgn_en,
  input  wire [NR-1:0]    rgn_rd_ok,
  input  wire [NR-1:0]    rgn_wr_ok,
  // Verdict
  output wire             blocked
);
  wire [NR-1:0] hit;
  genvar i;
  generate
    for (i = 0; i < NR; i = i + 1) begin : g_rgn
      assign hit[i] = rgn_en[i] &&
                      (addr >= rgn_base[i*32 +: 32]) &&
                      (addr <= rgn_limit[i*32 +: 32]) &&
                      (is_write ? !rgn_wr_ok[i] : !rgn_rd_ok[i]);
    end
  endgenerate
  assign blocked = |hit;
endmodule

// >>> drc_engine.v
// Purpose: Sixteen-channel request-driven memory transfer engine
// Assumes: Inputs are synchronous to clk_sys; bus holds m_ack high one cycle
// Notes:   Configuration arrives on plain ports, no software-visible registers
`timescale 1ns/100ps
`include "drc_defs.vh"

module drc_engine #(
  parameter NCH = 16,
  parameter NLN = 32,
  parameter FD  = 4,
  parameter NR  = 4
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rstn,
  // Request sources
  input  wire [NLN-1:0]   periph_req,
  input  wire [3:0]       os_tick_cmp,
  input  wire             bs1_spi_rx_req,
  input  wire             bs1_spi_tx_req,
  // Channel control
  input  wire [NCH-1:0]   chan_enable,
  input  wire [NCH-1:0]   sw_request,
  // Request assignment write
  input  wire             asg_wr,
  input  wire [3:0]       asg_chan,
  input  wire [4:0]       asg_line,
  // Descriptor write
  input  wire             desc_wr,
  input  wire [3:0]       desc_chan,
  input  wire [`DRC_DESC_W-1:0] desc_data,
  input  wire             desc_par_flip,
  // Protected regions
  input  wire [NR*32-1:0] rgn_base,
  input  wire [NR*32-1:0] rgn_limit,
  input  wire [NR-1:0]    rgn_en,
  input  wire [NR-1:0]    rgn_rd_ok,
  input  wire [NR-1:0]    rgn_wr_ok,
  // Bus master
  output reg              m_req,
  output reg              m_we,
  output reg  [31:0]      m_addr,
  output reg  [1:0]       m_size,
  output reg  [63:0]      m_wdata,
  input  wire             m_ack,
  input  wire [63:0]      m_rdata,
  // Status
  output reg              busy_q,
  output reg  [3:0]       active_chan_q,
  output reg  [NCH-1:0]   done_chan_q,
  output reg              parity_err_q,
  output reg              mpu_err_q,
  output reg  [3:0]       err_chan_q
);
  // Descriptor store
  reg  [`DRC_DESC_W-1:0] desc_mem [0:NCH-1];
  reg  [NCH-1:0]         par_mem_q;

  reg  [NLN-1:0] lines_q;
  reg  [4:0]     asg_q [0:NCH-1];
  reg  [NCH-1:0] lvl_prev_q;
  reg  [NCH-1:0] pend_q;
  reg  [NCH-1:0] armed_q;
  reg  [2:0]     st_q;
  reg  [3:0]     ch_q;
  reg  [31:0]    src_q;
  reg  [31:0]    dst_q;
  reg  [15:0]    rem_q;
  reg  [1:0]     esz_q;
  reg  [1:0]     smode_q;
  reg  [1:0]     dmode_q;
  reg  [31:0]    offs_q;
  reg  [NCH-1:0] clr_pend;
  reg  [NCH-1:0] chain_set;
  reg            flush;

  wire [NLN-1:0]          routed;
  wire [NCH-1:0]          lvl;
  wire [NCH-1:0]          cand;
  reg  [3:0]              pick;
  reg                     pick_ok;
  wire [`DRC_DESC_W-1:0]  rd_desc;
  wire                    rd_par;
  wire                    blocked;
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire [63:0]             fifo_out_data;
  wire                    rd_done;
  wire                    wr_done;
  wire [31:0]             step;
  integer c;
  integer r;

  // Shared lines are plain OR: the sources are never enabled together
  assign routed = periph_req |
                  ({{(NLN-1){1'b0}}, os_tick_cmp[0]} << `DRC_OST_L0) |
                  ({{(NLN-1){1'b0}}, os_tick_cmp[1]} << `DRC_OST_L1) |
                  ({{(NLN-1){1'b0}}, os_tick_cmp[2]} << `DRC_OST_L2) |
                  ({{(NLN-1){1'b0}}, os_tick_cmp[3]} << `DRC_OST_L3) |
                  ({{(NLN-1){1'b0}}, bs1_spi_rx_req} << `DRC_BS1_RX_L) |
                  ({{(NLN-1){1'b0}}, bs1_spi_tx_req} << `DRC_BS1_TX_L);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_lvl
      assign lvl[g] = lines_q[asg_q[g]];
    end
  endgenerate

  assign cand    = pend_q & armed_q & chan_enable;
  assign rd_desc = desc_mem[ch_q];
  assign rd_par  = par_mem_q[ch_q];
  assign rd_done = (st_q == `DRC_ST_READ) && m_req && !m_we && m_ack;
  assign wr_done = (st_q == `DRC_ST_WRITE) && m_req && m_we && m_ack;
  assign step    = `DRC_ZERO32 | (32'h1 << esz_q);

  // Fixed priority, lowest channel first
  always @* begin
    pick    = 4'h0;
    pick_ok = 1'b0;
    for (c = NCH - 1; c >= 0; c = c - 1) begin
      if (cand[c]) begin
        pick    = c[3:0];
        pick_ok = 1'b1;
      end
    end
  end

  function [31:0] next_addr;
    input [31:0] a;
    input [1:0]  mode;
    input [31:0] inc;
    input [31:0] offs;
    begin
      if (mode == `DRC_AM_INCR) begin
        next_addr = a + inc;
      end else if (mode == `DRC_AM_OFFS) begin
        next_addr = a + offs;
      end else begin
        next_addr = a;
      end
    end
  endfunction

  drc_fifo #(.W(64), .D(FD)) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (flush),
    .in_valid  (rd_done),
    .in_ready  (fifo_in_ready),
    .in_data   (m_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (wr_done),
    .out_data  (fifo_out_data)
  );

  drc_region_check #(.NR(NR)) u_rgn (
    .addr      ((st_q == `DRC_ST_WRITE) ? dst_q : src_q),
    .is_write  (st_q == `DRC_ST_WRITE),
    .rgn_base  (rgn_base),
    .rgn_limit (rgn_limit),
    .rgn_en    (rgn_en),
    .rgn_rd_ok (rgn_rd_ok),
    .rgn_wr_ok (rgn_wr_ok),
    .blocked   (blocked)
  );

  // Descriptor writes; the flip input lets tests plant a parity fault
  always @(posedge clk_sys) begin
    if (desc_wr) begin
      desc_mem[desc_chan]  <= desc_data;
      par_mem_q[desc_chan] <= (^desc_data) ^ desc_par_flip;
    end
  end

  // Request lines, assignment and pending flags
  always @(posedge clk_sys) begin
    if (!rstn) begin
      lines_q    <= {NLN{1'b0}};
      lvl_prev_q <= {NCH{1'b0}};
      pend_q     <= {NCH{1'b0}};
      for (r = 0; r < NCH; r = r + 1) begin
        asg_q[r] <= r[4:0];
      end
    end else begin
      lines_q    <= routed;
      lvl_prev_q <= lvl;
      if (asg_wr) begin
        asg_q[asg_chan] <= asg_line;
      end
      // A set in the clearing cycle wins
      pend_q <= (pend_q & ~clr_pend) | (lvl & ~lvl_prev_q) | sw_request | chain_set;
    end
  end

  // Transfer sequencer
  always @(posedge clk_sys) begin
    if (!rstn) begin
      st_q          <= `DRC_ST_IDLE;
      ch_q          <= 4'h0;
      armed_q       <= {NCH{1'b0}};
      src_q         <= `DRC_ADDR_RST;
      dst_q         <= `DRC_ADDR_RST;
      rem_q         <= 16'h0000;
      esz_q         <= `DRC_SZ_8;
      smode_q       <= `DRC_AM_FIXED;
      dmode_q       <= `DRC_AM_FIXED;
      offs_q        <= `DRC_ZERO32;
      clr_pend      <= {NCH{1'b0}};
      chain_set     <= {NCH{1'b0}};
      flush         <= 1'b0;
      m_req         <= 1'b0;
      m_we          <= 1'b0;
      m_addr        <= `DRC_ADDR_RST;
      m_size        <= `DRC_SZ_8;
      m_wdata       <= `DRC_DATA_RST;
      busy_q        <= 1'b0;
      active_chan_q <= 4'h0;
      done_chan_q   <= {NCH{1'b0}};
      parity_err_q  <= 1'b0;
      mpu_err_q     <= 1'b0;
      err_chan_q    <= 4'h0;
    end else begin
      clr_pend     <= {NCH{1'b0}};
      chain_set    <= {NCH{1'b0}};
      flush        <= 1'b0;
      done_chan_q  <= {NCH{1'b0}};
      parity_err_q <= 1'b0;
      mpu_err_q    <= 1'b0;
      case (st_q)
        `DRC_ST_IDLE: begin
          busy_q <= 1'b0;
          if (pick_ok && clr_pend == {NCH{1'b0}}) begin
            ch_q           <= pick;
            active_chan_q  <= pick;
            clr_pend[pick] <= 1'b1;
            busy_q         <= 1'b1;
            st_q           <= `DRC_ST_LOAD;
          end
        end
        `DRC_ST_LOAD: begin
          if ((^rd_desc) != rd_par) begin
            parity_err_q  <= 1'b1;
            err_chan_q    <= ch_q;
            armed_q[ch_q] <= 1'b0;
            st_q          <= `DRC_ST_IDLE;
          end else begin
            src_q   <= rd_desc[`DRC_F_SRC];
            dst_q   <= rd_desc[`DRC_F_DST];
            rem_q   <= rd_desc[`DRC_F_CNT];
            esz_q   <= rd_desc[`DRC_F_ESZ];
            smode_q <= rd_desc[`DRC_F_SMODE];
            dmode_q <= rd_desc[`DRC_F_DMODE];
            offs_q  <= {{16{rd_desc[`DRC_F_OFFS_MSB]}}, rd_desc[`DRC_F_OFFS]};
            m_size  <= rd_desc[`DRC_F_ESZ];
            st_q    <= `DRC_ST_READ;
          end
        end
        `DRC_ST_READ: begin
          if (m_req) begin
            if (m_ack) begin
              m_req <= 1'b0;
              src_q <= next_addr(src_q, smode_q, step, offs_q);
              rem_q <= rem_q - 16'h0001;
            end
          end else if (rem_q != 16'h0000 && fifo_in_ready) begin
            if (blocked) begin
              mpu_err_q     <= 1'b1;
              err_chan_q    <= ch_q;
              armed_q[ch_q] <= 1'b0;
              flush         <= 1'b1;
              st_q          <= `DRC_ST_IDLE;
            end else begin
              m_req  <= 1'b1;
              m_we   <= 1'b0;
              m_addr <= src_q;
            end
          end else begin
            st_q <= `DRC_ST_WRITE;
          end
        end
        `DRC_ST_WRITE: begin
          if (m_req) begin
            if (m_ack) begin
              m_req <= 1'b0;
              m_we  <= 1'b0;
              dst_q <= next_addr(dst_q, dmode_q, step, offs_q);
            end
          end else if (fifo_out_valid) begin
            if (blocked) begin
              mpu_err_q     <= 1'b1;
              err_chan_q    <= ch_q;
              armed_q[ch_q] <= 1'b0;
              flush         <= 1'b1;
              st_q          <= `DRC_ST_IDLE;
            end else begin
              m_req   <= 1'b1;
              m_we    <= 1'b1;
              m_addr  <= dst_q;
              m_wdata <= fifo_out_data;
            end
          end else begin
            st_q <= (rem_q == 16'h0000) ? `DRC_ST_DONE : `DRC_ST_READ;
          end
        end
        `DRC_ST_DONE: begin
          done_chan_q[ch_q] <= 1'b1;
          // Auto-initiation keeps the channel armed on its stored descriptor
          if (!rd_desc[`DRC_F_AUTO] && !desc_wr) begin
            armed_q[ch_q] <= 1'b0;
          end
          if (rd_desc[`DRC_F_CHAIN]) begin
            chain_set[rd_desc[`DRC_F_CHAIN_CH]] <= 1'b1;
          end
          st_q <= `DRC_ST_IDLE;
        end
        default: begin
          st_q <= `DRC_ST_IDLE;
        end
      endcase
      // Placed after the case so a new descriptor beats a same-cycle disarm
      if (desc_wr) begin
        armed_q[desc_chan] <= 1'b1;
      end
    end
  end
endmodule

// >>> drc_mem_model.sv
// Purpose: Memory side of the engine's bus master port
// Assumes: One ack pulse per request, after wait_n idle cycles
// Notes:   Read data is a function of the address
`timescale 1ns/100ps
module drc_mem_model (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Bus
  input  wire        m_req,
  input  wire        m_we,
  input  wire [31:0] m_addr,
  output reg         m_ack,
  output reg  [63:0] m_rdata,
  // Pace
  input  wire [2:0]  wait_n
);
  reg [2:0] cnt_q;

  always @(posedge clk_sys) begin
    m_ack   <= 1'b0;
    // Stale data flips each cycle so it never looks valid
    m_rdata <= ~m_rdata;
    if (!rstn) begin
      cnt_q   <= 3'h0;
      m_rdata <= 64'h0;
    end else if (m_req && !m_ack) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q >= wait_n) begin
        m_ack   <= 1'b1;
        cnt_q   <= 3'h0;
        m_rdata <= {m_addr ^ 32'hA5A5_0000, m_addr};
      end
    end
  end
endmodule

// >>> drc_props.sv
// Purpose: Port-level checks of the transfer engine
// Assumes: Bound to the engine's top module
// Notes:   All checks in the clk_sys domain
`timescale 1ns/100ps
module drc_props #(
  parameter NCH = 16
) (
  input wire logic           clk_sys,
  input wire logic           rstn,
  input wire logic           m_req,
  input wire logic           m_we,
  input wire logic [31:0]    m_addr,
  input wire logic [1:0]     m_size,
  input wire logic [63:0]    m_wdata,
  input wire logic           m_ack,
  input wire logic           busy_q,
  input wire logic [3:0]     active_chan_q,
  input wire logic [NCH-1:0] done_chan_q,
  input wire logic           parity_err_q,
  input wire logic           mpu_err_q
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_req_hold;
    m_req && !m_ack |=> m_req && $stable({m_we, m_addr, m_size, m_wdata});
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop;
    m_req && m_ack |=> !m_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  // One idle cycle between beats is legal, so only the reason for a drop is checked
  property p_gap;
    $fell(m_req) |-> $past(m_ack);
  endproperty
  a_gap: assert property (p_gap) else $error("request dropped without ack");
  property p_busy_req;
    m_req |-> busy_q;
  endproperty
  a_busy_req: assert property (p_busy_req) else $error("bus used while idle");
  property p_parity_quiet;
    parity_err_q |-> !m_req ##1 !m_req;
  endproperty
  a_parity_quiet: assert property (p_parity_quiet) else $error("bus used after parity fault");
  property p_mpu_quiet;
    mpu_err_q |-> !m_req ##1 !m_req;
  endproperty
  a_mpu_quiet: assert property (p_mpu_quiet) else $error("bus used after blocked access");
  // Busy may stay high into the next block when another channel waits
  property p_done;
    |done_chan_q |-> $onehot(done_chan_q) && busy_q && done_chan_q[active_chan_q] ##1 done_chan_q == '0;
  endproperty
  a_done: assert property (p_done) else $error("bad completion pulse");
  property p_no_preempt;
    busy_q && $past(busy_q) && $past(done_chan_q) == '0 && !$past(parity_err_q) && !$past(mpu_err_q)
      |-> $stable(active_chan_q);
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("channel switched mid block");
  property p_pick;
    $rose(busy_q) |-> ##[1:4] (m_req || parity_err_q || mpu_err_q || |done_chan_q);
  endproperty
  a_pick: assert property (p_pick) else $error("picked channel did nothing");

  c_write: cover property (m_req && m_ack && m_we);
  c_parity: cover property (parity_err_q);
  c_mpu: cover property (mpu_err_q);
endmodule

bind drc_engine drc_props #(.NCH(NCH)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .m_req(m_req), .m_we(m_we), .m_addr(m_addr), .m_size(m_size),
  .m_wdata(m_wdata), .m_ack(m_ack), .busy_q(busy_q), .active_chan_q(active_chan_q),
  .done_chan_q(done_chan_q), .parity_err_q(parity_err_q), .mpu_err_q(mpu_err_q));

// >>> drc_engine_tb_top.sv
// Purpose: Self-checking bench for the transfer engine
// Assumes: Memory model answers every request
// Notes:   Bus beats are logged and compared per scenario
`timescale 1ns/100ps
module drc_engine_tb_top;
  logic clk_sys = 1'b0, rstn = 1'b0, asg_wr = 1'b0, desc_wr = 1'b0, desc_par_flip = 1'b0;
  logic bs1_spi_rx_req = 1'b0, bs1_spi_tx_req = 1'b0;
  logic [31:0] periph_req = 32'h0;
  logic [3:0] os_tick_cmp = 4'h0, asg_chan = 4'h0, desc_chan = 4'h0;
  logic [3:0] rgn_en = 4'h0, rgn_rd_ok = 4'h0, rgn_wr_ok = 4'h0;
  logic [15:0] chan_enable = 16'h0, sw_request = 16'h0;
  logic [4:0] asg_line = 5'h0;
  logic [107:0] desc_data = 108'h0;
  logic [127:0] rgn_base = 128'h0, rgn_limit = 128'h0;
  logic [2:0] wait_n = 3'h0;
  wire m_req, m_we, m_ack, busy_q, parity_err_q, mpu_err_q;
  wire [31:0] m_addr;
  wire [1:0] m_size;
  wire [63:0] m_wdata, m_rdata;
  wire [3:0] active_chan_q, err_chan_q;
  wire [15:0] done_chan_q;
  int failures = 0, checks_done = 0;
  logic [98:0] ops[$];

  drc_engine u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .periph_req(periph_req), .os_tick_cmp(os_tick_cmp),
    .bs1_spi_rx_req(bs1_spi_rx_req), .bs1_spi_tx_req(bs1_spi_tx_req), .chan_enable(chan_enable),
    .sw_request(sw_request), .asg_wr(asg_wr), .asg_chan(asg_chan), .asg_line(asg_line),
    .desc_wr(desc_wr), .desc_chan(desc_chan), .desc_data(desc_data), .desc_par_flip(desc_par_flip),
    .rgn_base(rgn_base), .rgn_limit(rgn_limit), .rgn_en(rgn_en), .rgn_rd_ok(rgn_rd_ok),
    .rgn_wr_ok(rgn_wr_ok), .m_req(m_req), .m_we(m_we), .m_addr(m_addr), .m_size(m_size),
    .m_wdata(m_wdata), .m_ack(m_ack), .m_rdata(m_rdata), .busy_q(busy_q), .active_chan_q(active_chan_q),
    .done_chan_q(done_chan_q), .parity_err_q(parity_err_q), .mpu_err_q(mpu_err_q), .err_chan_q(err_chan_q));
  drc_mem_model u_mem (
    .clk_sys(clk_sys), .rstn(rstn), .m_req(m_req), .m_we(m_we), .m_addr(m_addr), .m_ack(m_ack),
    .m_rdata(m_rdata), .wait_n(wait_n));

  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rstn && m_req && m_ack) ops.push_back({m_we, m_size, m_addr, m_we ? m_wdata : m_rdata});

  task automatic chk(input logic [98:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Waits on {mpu error, parity error, done bits}; a lost pulse ends the run
  task automatic wait_bit(input int b);
    int i;
    logic [17:0] flags;
    for (i = 0; i < 200; i++) begin
      flags = {mpu_err_q, parity_err_q, done_chan_q};
      if (flags[b] === 1'b1) break;
      tick(1);
    end
    if (i == 200) begin
      chk(0, 1);
      finish_test();
    end
  endtask
  task automatic desc(input [3:0] ch, input [31:0] s, d, input [15:0] n, input [1:0] sz, sm, dm,
                      input [21:0] ext, input flip);
    desc_chan = ch;
    desc_data = {ext, dm, sm, sz, n, d, s};
    desc_par_flip = flip;
    desc_wr = 1'b1;
    chan_enable[ch] = 1'b1;
    tick(1);
    desc_wr = 1'b0;
    desc_par_flip = 1'b0;
    tick(1);
  endtask
  task automatic sw(input [15:0] m);
    sw_request = m;
    tick(1);
    sw_request = 16'h0;
  endtask
  function automatic logic [31:0] addr_of(input logic [31:0] b, input int m, e, sz, input logic [15:0] o);
    return m == 0 ? b : m == 1 ? b + (e << sz) : b + e * {{16{o[15]}}, o};
  endfunction

  // Six elements per size: four reads fill the buffer, then drain, then two more
  task automatic t_sizes;
    int i, e;
    logic w;
    logic [31:0] sa, da;
    for (int k = 0; k < 4; k++) begin
      ops.delete();
      wait_n = k[2:0];
      desc(0, 32'h1000, 32'h2000, 6, k[1:0], 2'(k % 3), 2'((k + 1) % 3), 22'hFFF8, 0);
      sw(16'h1);
      wait_bit(0);
      chk(ops.size(), 12);
      for (i = 0; i < 12 && i < ops.size(); i++) begin
        e = (i < 8) ? i % 4 : 4 + (i - 8) % 2;
        w = (i < 8) ? i >= 4 : i >= 10;
        sa = addr_of(32'h1000, k % 3, e, k, 16'hFFF8);
        da = addr_of(32'h2000, (k + 1) % 3, e, k, 16'hFFF8);
        chk(ops[i], {w, k[1:0], w ? da : sa, sa ^ 32'hA5A5_0000, sa});
      end
    end
    wait_n = 3'h0;
  endtask
  // One source per line at a time, each start lands on its assigned channel
  task automatic t_hw_map;
    int chs[7] = '{0, 1, 12, 13, 2, 3, 5};
    for (int j = 2; j < 4; j++) begin
      asg_chan = 4'(j);
      asg_line = 5'(j + 16);
      asg_wr = 1'b1;
      tick(1);
      asg_wr = 1'b0;
      tick(1);
    end
    for (int j = 0; j < 7; j++) begin
      desc(4'(chs[j]), 32'h3000, 32'h4000, 1, 2'h2, 2'h1, 2'h1, 22'h0, 0);
      {periph_req[5], os_tick_cmp, bs1_spi_tx_req, bs1_spi_rx_req} = 7'h1 << j;
      wait_bit(chs[j]);
      chk(active_chan_q, chs[j]);
      {periph_req[5], os_tick_cmp, bs1_spi_tx_req, bs1_spi_rx_req} = 7'h0;
      tick(3);
    end
  endtask
  // Channel 3 disabled: 7 then 9 served in order, 3 held until enabled
  task automatic t_prio;
    desc(3, 32'h10, 32'h20, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    desc(7, 32'h30, 32'h40, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    desc(9, 32'h50, 32'h60, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    chan_enable[3] = 1'b0;
    ops.delete();
    sw(16'h0288);
    wait_bit(7);
    chk(ops.size(), 2);
    wait_bit(9);
    tick(30);
    chk({busy_q, 32'(ops.size())}, 4);
    chan_enable[3] = 1'b1;
    wait_bit(3);
  endtask
  task automatic t_parity;
    ops.delete();
    desc(4, 32'h10, 32'h20, 1, 2'h3, 2'h1, 2'h1, 22'h0, 1);
    sw(16'h0010);
    wait_bit(16);
    chk(err_chan_q, 4);
    sw(16'h0010);
    tick(20);
    chk(ops.size(), 0);
  endtask
  // Region 0 forbids writes to the destination; the read still goes out
  task automatic t_region;
    rgn_base[31:0] = 32'h2000;
    rgn_limit[31:0] = 32'h20FF;
    {rgn_en, rgn_rd_ok, rgn_wr_ok} = 12'h110;
    ops.delete();
    desc(5, 32'h1000, 32'h2000, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    sw(16'h0020);
    wait_bit(17);
    chk(err_chan_q, 5);
    tick(10);
    chk(ops.size(), 1);
    rgn_en = 4'h0;
    desc(5, 32'h1000, 32'h2000, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    sw(16'h0020);
    wait_bit(5);
  endtask
  // Channel 8 chains to 10 and re-arms itself; 10 runs only once
  task automatic t_chain;
    ops.delete();
    desc(8, 32'h100, 32'h200, 1, 2'h3, 2'h1, 2'h1, {1'b1, 4'hA, 1'b1, 16'h0}, 0);
    desc(10, 32'h300, 32'h400, 1, 2'h3, 2'h1, 2'h1, 22'h0, 0);
    sw(16'h0100);
    wait_bit(8);
    wait_bit(10);
    tick(2);
    sw(16'h0100);
    wait_bit(8);
    tick(30);
    chk(ops.size(), 6);
  endtask

  initial begin
    tick(3);
    rstn = 1'b1;
    t_sizes();
    t_hw_map();
    t_prio();
    t_parity();
    t_region();
    t_chain();
    finish_test();
  end
endmodule
